// ===== rtl/dbgtr_pkg.sv
package dbgtr_pkg;

  localparam int unsigned ADDR_WIDTH   = 16;
  localparam int unsigned DATA_WIDTH   = 8;
  localparam int unsigned REG_AW       = 4;
  localparam int unsigned TRACE_DEPTH  = 8;
  localparam int unsigned TRACE_CNT_W  = 4;

  localparam logic [3:0] OFS_CMP_A_HI   = 4'h0;
  localparam logic [3:0] OFS_CMP_A_LO   = 4'h1;
  localparam logic [3:0] OFS_CMP_B_HI   = 4'h2;
  localparam logic [3:0] OFS_CMP_B_LO   = 4'h3;
  localparam logic [3:0] OFS_TRIG_CTRL  = 4'h4;
  localparam logic [3:0] OFS_DBG_CTRL   = 4'h5;
  localparam logic [3:0] OFS_DBG_STATUS = 4'h6;
  localparam logic [3:0] OFS_INT_STATUS = 4'h7;
  localparam logic [3:0] OFS_INT_MASK   = 4'h8;

  localparam int unsigned TC_BEGIN_BIT  = 7;
  localparam int unsigned TC_TRIGGER_KIND_SELECT_BIT = 6;
  localparam int unsigned TC_MODE_LSB   = 0;
  localparam int unsigned DC_ARM_BIT    = 7;
  localparam int unsigned DC_BREAKPOINT_REQUEST_ENABLE_BIT  = 6;
  localparam int unsigned DC_TAG_BIT    = 5;
  localparam int unsigned DS_AF_BIT     = 7;
  localparam int unsigned DS_BF_BIT     = 6;
  localparam int unsigned DS_ARMED_BIT  = 5;
  localparam int unsigned DS_TRIG_BIT   = 4;
  localparam int unsigned DS_FULL_BIT   = 3;
  localparam int unsigned DS_BREAK_BIT  = 2;
  localparam int unsigned IRQ_TRIG_BIT  = 0;
  localparam int unsigned IRQ_FULL_BIT  = 1;
  localparam int unsigned IRQ_BREAK_BIT = 2;

  localparam logic [1:0] MODE_A_NOT_B   = 2'h0;
  localparam logic [1:0] MODE_INSIDE    = 2'h1;
  localparam logic [1:0] MODE_OUTSIDE   = 2'h2;

  localparam logic [15:0] CMP_RESET     = 16'h0000;
  localparam logic [7:0]  REG8_RESET    = 8'h00;
  localparam logic [1:0]  MODE_RESET    = 2'h0;

endpackage : dbgtr_pkg

// ===== rtl/dbgtr_compare.sv
`timescale 1ns/1ps
`default_nettype none
module dbgtr_compare
(
  input  wire logic [15:0] value,
  input  wire logic [15:0] ref_value,
  output logic             equal,
  output logic             ref_le_value,
  output logic             value_le_ref
);

  always_comb
  begin
    equal        = (value == ref_value);
    ref_le_value = (ref_value <= value);
    value_le_ref = (value <= ref_value);
  end

endmodule : dbgtr_compare
`default_nettype wire

// ===== rtl/dbgtr_trace_count.sv
`timescale 1ns/1ps
`default_nettype none
module dbgtr_trace_count
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic clear,
  input  wire logic store,
  output logic      full
);

  logic [dbgtr_pkg::TRACE_CNT_W-1:0] count_reg;

  // Counting saturates at the depth so a late store cannot wrap it.
  always_ff @(posedge ref_clk)
  begin
    if (reset || clear)
      count_reg <= '0;
    else if (store && !full)
      count_reg <= count_reg + 1'b1;
  end

  always_comb
  begin
    full = (count_reg == dbgtr_pkg::TRACE_CNT_W'(dbgtr_pkg::TRACE_DEPTH));
  end

endmodule : dbgtr_trace_count
`default_nettype wire

// ===== rtl/dbgtr_run_control.sv
// Behaviour
// - A-and-not-B mode: comparator A watches address, comparator B watches data.
// - A-and-not-B: A match with B mismatch in one cycle sets both flags.
// - A-and-not-B: only one of the two conditions leaves both flags unchanged.
// - Tagged end-trigger in A-and-not-B triggers on comparator A matches alone.
// - Inside range: A at most address at most B sets both flags.
// - Inside range: only one bound met sets no flag.
// - Outside range: address below A or above B sets that comparator's flag.
// - Run type comes from begin, trigger kind, breakpoint enable and tag.
// - End-trigger on address without break: trace until trigger, CPU runs.
// - End-trigger on address with break, no tag: trace until trigger, then break.
// - End-trigger on opcode without break: trace until opcode executes, CPU runs.
// - End-trigger on opcode with break and tag: trace until opcode, then break.
// - Begin-trigger on address without break: trace starts at trigger, CPU runs.
// - Begin-trigger on address with break, no tag: start at trigger, break when full.
// - Begin-trigger on opcode without break: trace starts at opcode, CPU runs.
// - Begin-trigger on opcode with break, no tag: break when trace full.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dbgtr_run_control
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_data,
  input  wire logic        cpu_bus_cycle,
  input  wire logic        cpu_opcode_exec,
  output logic             trace_store,
  output logic             trace_active,
  output logic             cpu_break_req,
  output logic             irq
);

  typedef enum logic [3:0]
  {
    ST_IDLE    = 4'b0001,
    ST_WAIT    = 4'b0010,
    ST_CAPTURE = 4'b0100,
    ST_DONE    = 4'b1000
  } dbgtr_state_type;

  dbgtr_state_type state_reg;
  dbgtr_state_type state_next;

  logic [15:0] cmp_a_reg;
  logic [15:0] cmp_b_reg;
  logic        begin_reg;
  logic        trigger_kind_select_reg;
  logic [1:0]  mode_reg;
  logic        breakpoint_request_enable_reg;
  logic        tag_reg;
  logic        comparator_a_flag;
  logic        comparator_b_flag;
  logic        triggered_reg;
  logic        break_reg;
  logic [2:0]  int_status_reg;
  logic [2:0]  int_mask_reg;

  logic        a_addr_eq;
  logic        a_le_addr;
  logic        addr_le_a;
  logic        b_le_addr;
  logic        addr_le_b;
  logic        b_data_eq;
  logic        set_af;
  logic        set_bf;
  logic        trigger_hit;
  logic        trigger_event;
  logic        store_now;
  logic        fifo_full;
  logic        break_event;
  logic        full_event;
  logic        arm_write;
  logic        disarm_write;
  logic        ctrl_write;

  function automatic logic is_write(input logic [3:0] offset);
    is_write = reg_write && (reg_addr == offset);
  endfunction : is_write

  dbgtr_compare u_cmp_a
  (
    .value        (cpu_addr),
    .ref_value    (cmp_a_reg),
    .equal        (a_addr_eq),
    .ref_le_value (a_le_addr),
    .value_le_ref (addr_le_a)
  );

  dbgtr_compare u_cmp_b
  (
    .value        (cpu_addr),
    .ref_value    (cmp_b_reg),
    .equal        (),
    .ref_le_value (b_le_addr),
    .value_le_ref (addr_le_b)
  );

  dbgtr_trace_count u_trace_count
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clear   (arm_write),
    .store   (store_now),
    .full    (fifo_full)
  );

  always_comb
  begin
    ctrl_write   = is_write(dbgtr_pkg::OFS_DBG_CTRL);
    arm_write    = ctrl_write && reg_wdata[dbgtr_pkg::DC_ARM_BIT];
    disarm_write = ctrl_write && !reg_wdata[dbgtr_pkg::DC_ARM_BIT];
    b_data_eq    = (cpu_data == cmp_b_reg[7:0]);
  end

  // Flag setting per trigger mode; the unused mode code never sets a flag.
  always_comb
  begin
    set_af = 1'b0;
    set_bf = 1'b0;
    if (cpu_bus_cycle)
    begin
      unique case (mode_reg)
        dbgtr_pkg::MODE_A_NOT_B:
        begin
          set_af = a_addr_eq && !b_data_eq;
          set_bf = a_addr_eq && !b_data_eq;
        end
        dbgtr_pkg::MODE_INSIDE:
        begin
          set_af = a_le_addr && addr_le_b;
          set_bf = a_le_addr && addr_le_b;
        end
        dbgtr_pkg::MODE_OUTSIDE:
        begin
          set_af = !a_le_addr;
          set_bf = !addr_le_b;
        end
        default:
        begin
          set_af = 1'b0;
          set_bf = 1'b0;
        end
      endcase
    end
  end

  // A tagged end-trigger in A-and-not-B mode looks at comparator A only.
  always_comb
  begin
    if (tag_reg && !begin_reg && (mode_reg == dbgtr_pkg::MODE_A_NOT_B))
      trigger_hit = cpu_bus_cycle && a_addr_eq;
    else
      trigger_hit = set_af || set_bf;
    if (trigger_kind_select_reg)
      trigger_event = trigger_hit && cpu_opcode_exec;
    else
      trigger_event = trigger_hit;
  end

  // Capture runs before the trigger for end runs and after it for begin runs.
  always_comb
  begin
    store_now = cpu_bus_cycle && !fifo_full &&
                (((state_reg == ST_WAIT) && !begin_reg) ||
                 (state_reg == ST_CAPTURE));
  end

  // Break decision from the run type; the unused combinations never break.
  always_comb
  begin
    break_event = 1'b0;
    full_event  = 1'b0;
    if ((state_reg == ST_WAIT) && trigger_event && !begin_reg && breakpoint_request_enable_reg)
      break_event = trigger_kind_select_reg ? tag_reg : !tag_reg;
    if ((state_reg == ST_CAPTURE) && fifo_full)
    begin
      full_event  = 1'b1;
      break_event = breakpoint_request_enable_reg && !tag_reg;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (arm_write)
          state_next = ST_WAIT;
      ST_WAIT:
        if (disarm_write)
          state_next = ST_IDLE;
        else if (trigger_event)
          state_next = begin_reg ? ST_CAPTURE : ST_DONE;
      ST_CAPTURE:
        if (disarm_write)
          state_next = ST_IDLE;
        else if (fifo_full)
          state_next = ST_DONE;
      ST_DONE:
        if (disarm_write)
          state_next = ST_IDLE;
        else if (arm_write)
          state_next = ST_WAIT;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cmp_a_reg <= dbgtr_pkg::CMP_RESET;
      cmp_b_reg <= dbgtr_pkg::CMP_RESET;
    end
    else
    begin
      if (is_write(dbgtr_pkg::OFS_CMP_A_HI))
        cmp_a_reg[15:8] <= reg_wdata;
      if (is_write(dbgtr_pkg::OFS_CMP_A_LO))
        cmp_a_reg[7:0] <= reg_wdata;
      if (is_write(dbgtr_pkg::OFS_CMP_B_HI))
        cmp_b_reg[15:8] <= reg_wdata;
      if (is_write(dbgtr_pkg::OFS_CMP_B_LO))
        cmp_b_reg[7:0] <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      begin_reg  <= 1'b0;
      trigger_kind_select_reg <= 1'b0;
      mode_reg   <= dbgtr_pkg::MODE_RESET;
      breakpoint_request_enable_reg  <= 1'b0;
      tag_reg    <= 1'b0;
    end
    else
    begin
      if (is_write(dbgtr_pkg::OFS_TRIG_CTRL))
      begin
        begin_reg  <= reg_wdata[dbgtr_pkg::TC_BEGIN_BIT];
        trigger_kind_select_reg <= reg_wdata[dbgtr_pkg::TC_TRIGGER_KIND_SELECT_BIT];
        mode_reg   <= reg_wdata[dbgtr_pkg::TC_MODE_LSB +: 2];
      end
      if (ctrl_write)
      begin
        breakpoint_request_enable_reg <= reg_wdata[dbgtr_pkg::DC_BREAKPOINT_REQUEST_ENABLE_BIT];
        tag_reg   <= reg_wdata[dbgtr_pkg::DC_TAG_BIT];
      end
    end
  end

  // Arming clears the flags; a match in the same cycle sets them only if already in ST_WAIT.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      comparator_a_flag <= 1'b0;
      comparator_b_flag <= 1'b0;
    end
    else
    begin
      comparator_a_flag <= (comparator_a_flag && !arm_write) ||
                           (set_af && (state_reg == ST_WAIT));
      comparator_b_flag <= (comparator_b_flag && !arm_write) ||
                           (set_bf && (state_reg == ST_WAIT));
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      triggered_reg <= 1'b0;
      break_reg     <= 1'b0;
    end
    else
    begin
      triggered_reg <= (triggered_reg && !arm_write && !disarm_write) ||
                       ((state_reg == ST_WAIT) && trigger_event);
      // The break request holds until software disarms or re-arms, so the core cannot miss it.
      break_reg     <= (break_reg && !disarm_write && !arm_write) ||
                       break_event;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      trace_store   <= 1'b0;
      trace_active  <= 1'b0;
      cpu_break_req <= 1'b0;
    end
    else
    begin
      trace_store   <= store_now;
      trace_active  <= ((state_next == ST_WAIT) && !begin_reg) ||
                       (state_next == ST_CAPTURE);
      cpu_break_req <= (break_reg && !disarm_write && !arm_write) || break_event;
    end
  end

  // Event bits are write-one-to-clear; a new event in the clearing cycle wins.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      int_status_reg <= 3'h0;
      int_mask_reg   <= 3'h0;
      irq            <= 1'b0;
    end
    else
    begin
      int_status_reg[dbgtr_pkg::IRQ_TRIG_BIT] <=
        (int_status_reg[dbgtr_pkg::IRQ_TRIG_BIT] &&
         !(is_write(dbgtr_pkg::OFS_INT_STATUS) && reg_wdata[dbgtr_pkg::IRQ_TRIG_BIT])) ||
        ((state_reg == ST_WAIT) && trigger_event);
      int_status_reg[dbgtr_pkg::IRQ_FULL_BIT] <=
        (int_status_reg[dbgtr_pkg::IRQ_FULL_BIT] &&
         !(is_write(dbgtr_pkg::OFS_INT_STATUS) && reg_wdata[dbgtr_pkg::IRQ_FULL_BIT])) ||
        full_event;
      int_status_reg[dbgtr_pkg::IRQ_BREAK_BIT] <=
        (int_status_reg[dbgtr_pkg::IRQ_BREAK_BIT] &&
         !(is_write(dbgtr_pkg::OFS_INT_STATUS) && reg_wdata[dbgtr_pkg::IRQ_BREAK_BIT])) ||
        break_event;
      if (is_write(dbgtr_pkg::OFS_INT_MASK))
        int_mask_reg <= reg_wdata[2:0];
      irq <= |(int_status_reg & int_mask_reg);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reg_rdata <= dbgtr_pkg::REG8_RESET;
    else if (reg_read)
    begin
      unique case (reg_addr)
        dbgtr_pkg::OFS_CMP_A_HI:   reg_rdata <= cmp_a_reg[15:8];
        dbgtr_pkg::OFS_CMP_A_LO:   reg_rdata <= cmp_a_reg[7:0];
        dbgtr_pkg::OFS_CMP_B_HI:   reg_rdata <= cmp_b_reg[15:8];
        dbgtr_pkg::OFS_CMP_B_LO:   reg_rdata <= cmp_b_reg[7:0];
        dbgtr_pkg::OFS_TRIG_CTRL:  reg_rdata <= {begin_reg, trigger_kind_select_reg, 4'h0, mode_reg};
        dbgtr_pkg::OFS_DBG_CTRL:   reg_rdata <= {(state_reg != ST_IDLE), breakpoint_request_enable_reg,
                                                 tag_reg, 5'h00};
        dbgtr_pkg::OFS_DBG_STATUS: reg_rdata <= {comparator_a_flag, comparator_b_flag,
                                                 (state_reg != ST_IDLE), triggered_reg,
                                                 fifo_full, break_reg, 2'h0};
        dbgtr_pkg::OFS_INT_STATUS: reg_rdata <= {5'h00, int_status_reg};
        dbgtr_pkg::OFS_INT_MASK:   reg_rdata <= {5'h00, int_mask_reg};
        default:                   reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule : dbgtr_run_control
`default_nettype wire

// ===== testbench/dbgtr_run_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dbgtr_run_control_sva
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        trace_store,
  input wire logic        trace_active,
  input wire logic        cpu_break_req,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_rdata_idle;
    !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its slot");
  property p_unmapped;
    reg_read && reg_addr > 4'h8 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped index read not zero");
  property p_store_cause;
    trace_store |-> $past(trace_active);
  endproperty
  a_store_cause: assert property (p_store_cause)
    else $error("trace store without open capture");
  property p_break_hold;
    cpu_break_req && !(reg_write && reg_addr == 4'h5) |=> cpu_break_req;
  endproperty
  a_break_hold: assert property (p_break_hold)
    else $error("breakpoint dropped without control write");
  property p_break_release;
    $fell(cpu_break_req) |-> $past(reg_write) && $past(reg_addr) == 4'h5;
  endproperty
  a_break_release: assert property (p_break_release)
    else $error("breakpoint released by something else");
  property p_break_no_trace;
    cpu_break_req |-> !trace_active;
  endproperty
  a_break_no_trace: assert property (p_break_no_trace)
    else $error("capture open during breakpoint");
  property p_break_quiet;
    cpu_break_req |=> !trace_store;
  endproperty
  a_break_quiet: assert property (p_break_quiet)
    else $error("trace stored after breakpoint");
  property p_reset_quiet;
    $fell(reset) |-> !cpu_break_req && !trace_active && !irq && !trace_store;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output active after reset");
  property p_mask_off;
    reg_write && reg_addr == 4'h8 && reg_wdata[2:0] == 3'h0 |=> ##1 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt high with all sources masked");
endmodule : dbgtr_run_control_sva

bind dbgtr_run_control dbgtr_run_control_sva u_sva
(
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .trace_store(trace_store), .trace_active(trace_active),
  .cpu_break_req(cpu_break_req), .irq(irq)
);
`default_nettype wire

// ===== testbench/dbgtr_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbgtr_cpu_model
(
  input  wire logic        ref_clk,
  input  wire logic        cpu_break_req,
  output logic      [15:0] cpu_addr,
  output logic      [7:0]  cpu_data,
  output logic             cpu_bus_cycle,
  output logic             cpu_opcode_exec
);
  initial
  begin
    cpu_addr = 16'h0000;
    cpu_data = 8'h00;
    cpu_bus_cycle = 1'b0;
    cpu_opcode_exec = 1'b0;
  end

  // A halted core issues no bus cycles; released buses never keep the last value.
  task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic op);
    @(posedge ref_clk);
    if (cpu_break_req !== 1'b1)
    begin
      cpu_addr <= a;
      cpu_data <= d;
      cpu_bus_cycle <= 1'b1;
      cpu_opcode_exec <= op;
    end
    @(posedge ref_clk);
    cpu_bus_cycle <= 1'b0;
    cpu_opcode_exec <= 1'b0;
    cpu_addr <= ~a;
    cpu_data <= ~d;
  endtask : cycle
endmodule : dbgtr_cpu_model
`default_nettype wire

// ===== testbench/debug_trigger_run_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module debug_trigger_run_control_test;
  logic        ref_clk;
  logic        reset;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_rdata;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_data;
  logic        cpu_bus_cycle;
  logic        cpu_opcode_exec;
  logic        trace_store;
  logic        trace_active;
  logic        cpu_break_req;
  logic        irq;
  integer      n_errors;
  integer      checks;
  integer      n_store;

  dbgtr_run_control u_dut
  (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_bus_cycle(cpu_bus_cycle),
    .cpu_opcode_exec(cpu_opcode_exec), .trace_store(trace_store),
    .trace_active(trace_active), .cpu_break_req(cpu_break_req), .irq(irq)
  );

  dbgtr_cpu_model u_cpu
  (
    .ref_clk(ref_clk), .cpu_break_req(cpu_break_req), .cpu_addr(cpu_addr),
    .cpu_data(cpu_data), .cpu_bus_cycle(cpu_bus_cycle), .cpu_opcode_exec(cpu_opcode_exec)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
    if (trace_store === 1'b1)
      n_store <= n_store + 1;

  task print_verdict;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Only documented run types are armed; the unused ones are left alone.
  task arm(input logic [15:0] a, input logic [15:0] b, input logic [7:0] tc, input logic [7:0] dc);
    wr(4'h0, a[15:8]);
    wr(4'h1, a[7:0]);
    wr(4'h2, b[15:8]);
    wr(4'h3, b[7:0]);
    wr(4'h4, tc);
    wr(4'h5, dc | 8'h80);
  endtask : arm

  task s_regs;
    logic [7:0] d;
    rd(4'h6, d);
    chk(d, 8'h00);
    wr(4'h4, 8'hC2);
    rd(4'h4, d);
    chk(d, 8'hC2);
    rd(4'hF, d);
    chk(d, 8'h00);
  endtask : s_regs

  task s_anotb;
    logic [7:0] d;
    arm(16'h1234, 16'h0055, 8'h00, 8'h40);
    u_cpu.cycle(16'h1234, 8'h55, 1'b0);
    u_cpu.cycle(16'h1000, 8'h00, 1'b0);
    rd(4'h6, d);
    chk(d & 8'hC4, 8'h00);
    chk({7'h00, trace_active}, 8'h01);
    u_cpu.cycle(16'h1234, 8'h00, 1'b0);
    rd(4'h6, d);
    chk(d & 8'hC4, 8'hC4);
    chk({7'h00, cpu_break_req}, 8'h01);
    chk({7'h00, trace_active}, 8'h00);
  endtask : s_anotb

  task s_range;
    logic [7:0] d;
    arm(16'h2000, 16'h2FFF, 8'h01, 8'h00);
    u_cpu.cycle(16'h1FFF, 8'h00, 1'b0);
    u_cpu.cycle(16'h3000, 8'h00, 1'b0);
    rd(4'h6, d);
    chk(d & 8'hC0, 8'h00);
    u_cpu.cycle(16'h2000, 8'h00, 1'b0);
    rd(4'h6, d);
    chk(d & 8'hC0, 8'hC0);
    chk({7'h00, cpu_break_req}, 8'h00);
    arm(16'h2000, 16'h2FFF, 8'h02, 8'h00);
    u_cpu.cycle(16'h3000, 8'h00, 1'b0);
    rd(4'h6, d);
    chk(d & 8'hC0, 8'h40);
    arm(16'h2000, 16'h2FFF, 8'h02, 8'h00);
    u_cpu.cycle(16'h1000, 8'h00, 1'b0);
    rd(4'h6, d);
    chk(d & 8'hC0, 8'h80);
  endtask : s_range

  task s_tag;
    arm(16'h4000, 16'h0077, 8'h40, 8'h60);
    u_cpu.cycle(16'h4000, 8'h00, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk({7'h00, cpu_break_req}, 8'h00);
    u_cpu.cycle(16'h4000, 8'h77, 1'b1);
    repeat (2) @(posedge ref_clk);
    chk({7'h00, cpu_break_req}, 8'h01);
  endtask : s_tag

  task s_begin;
    logic [7:0] d;
    integer     i;
    wr(4'h8, 8'h02);
    arm(16'h5000, 16'h0000, 8'h80, 8'h40);
    n_store = 0;
    u_cpu.cycle(16'h5000, 8'h11, 1'b0);
    for (i = 0; i < 8; i++)
      u_cpu.cycle(16'h6000, 8'h00, 1'b0);
    for (i = 0; i < 20 && cpu_break_req !== 1'b1; i++)
      @(posedge ref_clk);
    // The interrupt line lags the status bit by one clock, so look away from the edge.
    @(negedge ref_clk);
    chk(n_store[7:0], 8'h08);
    chk({7'h00, cpu_break_req}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    if (cpu_break_req !== 1'b1)
      print_verdict;
    wr(4'h8, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk({7'h00, irq}, 8'h00);
    rd(4'h7, d);
    chk(d, 8'h07);
    wr(4'h7, 8'h07);
    rd(4'h7, d);
    chk(d, 8'h00);
  endtask : s_begin

  task s_opcode;
    logic [7:0] d;
    arm(16'h7000, 16'h0000, 8'h40, 8'h00);
    u_cpu.cycle(16'h7000, 8'h11, 1'b0);
    rd(4'h6, d);
    chk(d & 8'h10, 8'h00);
    u_cpu.cycle(16'h7000, 8'h11, 1'b1);
    rd(4'h6, d);
    chk(d & 8'h14, 8'h10);
    chk({7'h00, cpu_break_req}, 8'h00);
    arm(16'h7000, 16'h0000, 8'hC0, 8'h00);
    n_store = 0;
    u_cpu.cycle(16'h7000, 8'h11, 1'b1);
    repeat (8) u_cpu.cycle(16'h6000, 8'h00, 1'b0);
    repeat (3) @(posedge ref_clk);
    rd(4'h6, d);
    chk(d & 8'h1C, 8'h18);
    chk(n_store[7:0], 8'h08);
    chk({7'h00, cpu_break_req}, 8'h00);
  endtask : s_opcode

  initial
  begin
    n_errors = 0;
    checks = 0;
    n_store = 0;
    reset = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    s_regs;
    s_anotb;
    s_range;
    s_tag;
    s_begin;
    s_opcode;
    print_verdict;
  end
endmodule : debug_trigger_run_control_test
`default_nettype wire
